// ===== verilog/sacb_map.vh
// Purpose: register offsets, field positions, reset values for the uart core
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: all offsets are byte addresses
`ifndef SACB_MAP_VH
`define SACB_MAP_VH
`define SACB_OFF_BDH 12'h000
`define SACB_OFF_BDL 12'h004
`define SACB_OFF_OPT 12'h008
`define SACB_OFF_CTL 12'h00c
`define SACB_OFF_STAT 12'h010
`define SACB_OFF_DATA 12'h014
`define SACB_OFF_EXT 12'h018
`define SACB_BDL_RST 8'h04
`define SACB_OPT_LOOP 7
`define SACB_OPT_SWAI 6
`define SACB_OPT_RECEIVER_SOURCE 5
`define SACB_OPT_NINE 4
`define SACB_OPT_WAKE 3
`define SACB_OPT_ILT 2
`define SACB_OPT_PE 1
`define SACB_OPT_PT 0
`define SACB_CTL_TXON 3
`define SACB_CTL_RXON 2
`define SACB_CTL_SLEEP 1
`define SACB_CTL_BRK 0
`define SACB_EXT_R9 7
`define SACB_EXT_T9 6
`define SACB_EXT_DIR 5
`define SACB_EXT_INV 4
`define SACB_EXT_BRK13 3
`define SACB_OVS 5'd16
`define SACB_IDLE_BITS 4'd10
`endif

// ===== verilog/sacb_core.v
// Purpose: asynchronous serial core with baud divisor and option control
// Assumes: single 50 MHz clock, apb slave, line input is asynchronous
// Notes: status flags clear by write of one; set wins over clear
`timescale 1ns/1ps
`include "sacb_map.vh"

// Contract
// [R1] bit rate is clock over sixteen times divisor for divisor 1..8191
// [R2] divisor zero stops the baud generator, no ticks at all
// [R3] high half is buffered; both halves load when low half is written
// [R4] low half resets nonzero; generator off until tx or rx first enabled
// [R5] high register holds divisor 12:8 in 4:0, low holds 7:0
// [R6] loop select routes transmitter into receiver, receive pin unused
// [R7] receiver source picks internal loop or single-wire on transmit pin
// [R8] stop-in-wait set freezes the block while the cpu waits
// [R9] frame is start, eight data lsb first, optional ninth, then stop
// [R10] wake method selects idle-line or address-mark wakeup
// [R11] idle needs ten or eleven high bit times, counted after start or stop; the code counts only after the stop bit for either ilt setting
// [R12] parity enable generates and checks parity in the top data bit
// [R13] parity type selects even or odd count of ones including parity
// [R14] all transmit and receive activity halts in stop mode
// [R15] break character optionally lengthened to thirteen bit times
// [R16] host writes data only after tx empty, reads only after rx full
// [R17] ninth bits carried only in nine-bit mode
// [R18] transmitted serial data inverted when polarity invert set
// [R19] overrun, parity, framing and noise errors each get their own flag
// [R20] single-wire direction decides whether transmit pin drives or listens
// [R21] receiver samples at sixteen times baud, resyncs on start edge
module sacb_core (
  input wire I_CLK, // 50 MHz clock
  input wire I_RESET, // synchronous active high reset
  input wire I_PSEL, // apb select
  input wire I_PENABLE, // apb enable
  input wire I_PWRITE, // apb direction
  input wire [11:0] I_PADDR, // apb byte address
  input wire [31:0] I_PWDATA, // apb write data
  input wire I_WAIT, // cpu in wait mode
  input wire I_STOP, // system in stop mode
  input wire I_RXD, // receive pin
  input wire I_TXD_IN, // transmit pin level in
  output reg [31:0] O_PRDATA, // apb read data
  output reg O_PREADY, // apb ready
  output reg O_PSLVERR, // apb error
  output reg O_TXD, // transmit pin drive value
  output reg O_TXD_OE // transmit pin output enable
);

////////////////////////////////////////////////////////////////////////////
reg [4:0] bdh_buf;
reg [4:0] div_hi;
reg [7:0] div_lo;
reg [7:0] opt;
reg [3:0] ctl;
reg t9;
reg dir;
reg inv;
reg brk13;
reg gen_on;
reg [7:0] tx_buf;
reg tx_buf9;
reg tx_empty;
reg [7:0] rx_buf;
reg rx_buf9;
reg rx_full;
reg f_or;
reg f_pf;
reg f_fe;
reg f_nf;
reg f_idle;
reg f_tc;
reg [12:0] bcnt;
reg tick;
reg rx_s1;
reg rx_s2;
reg tl_s1;
reg tl_s2;

wire [12:0] div = {div_hi, div_lo}; // [R5]
wire frozen = I_STOP | (I_WAIT & opt[`SACB_OPT_SWAI]); // [R8] [R14]
wire nine = opt[`SACB_OPT_NINE];
wire acc = I_PSEL & I_PENABLE & ~O_PREADY;
wire wr = acc & I_PWRITE;
wire known = (I_PADDR <= `SACB_OFF_EXT) && (I_PADDR[1:0] == 2'b00);

function par_of;
  input [8:0] d;
  input ninem;
  input odd;
  begin
    par_of = (ninem ? ^d[7:0] : ^d[6:0]) ^ odd;
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// baud generator: one tick per 1/16 bit
always @(posedge I_CLK) begin
  if (I_RESET) begin
    bcnt <= 13'h0001;
    tick <= 1'b0;
  end else begin
    tick <= 1'b0;
    if (!gen_on || div == 13'h0000 || frozen) begin // [R2] [R4]
      bcnt <= 13'h0001;
    end else if (bcnt >= div) begin // [R1]
      bcnt <= 13'h0001;
      tick <= 1'b1;
    end else begin
      bcnt <= bcnt + 13'h0001;
    end
  end
end

always @(posedge I_CLK) begin
  if (I_RESET) begin
    rx_s1 <= 1'b1;
    rx_s2 <= 1'b1;
    tl_s1 <= 1'b1;
    tl_s2 <= 1'b1;
  end else begin
    rx_s1 <= I_RXD;
    rx_s2 <= rx_s1;
    tl_s1 <= I_TXD_IN;
    tl_s2 <= tl_s1;
  end
end

////////////////////////////////////////////////////////////////////////////
// transmitter
reg [3:0] tx_st;
reg [3:0] tx_sub;
reg [3:0] tx_bit;
reg [9:0] tx_sh;
reg tx_line;
reg tx_busy;
localparam TX_IDLE = 4'd0;
localparam TX_DATA = 4'd1;
localparam TX_BRK = 4'd2;
wire [3:0] tx_len = nine ? 4'd11 : 4'd10; // [R9]
wire [3:0] brk_len = brk13 ? 4'd13 : tx_len; // [R15]
wire tx_take = tx_st == TX_IDLE && ctl[`SACB_CTL_TXON] && tick;
reg [8:0] tx_fr;
always @* begin
  tx_fr = {tx_buf9 & nine, tx_buf}; // [R17]
  if (opt[`SACB_OPT_PE]) begin // [R12] [R13]
    if (nine)
      tx_fr[8] = par_of(tx_fr, 1'b1, opt[`SACB_OPT_PT]);
    else
      tx_fr[7] = par_of(tx_fr, 1'b0, opt[`SACB_OPT_PT]);
  end
end

////////////////////////////////////////////////////////////////////////////
// receiver
reg [3:0] rx_st;
reg [3:0] rx_sub;
reg [3:0] rx_bit;
reg [8:0] rx_sh;
reg [2:0] smp;
reg rx_prev;
reg rx_noise;
reg [7:0] idle_cnt;
reg idle_arm;
localparam RX_IDLE = 4'd0;
localparam RX_START = 4'd1;
localparam RX_DATA = 4'd2;
wire single = opt[`SACB_OPT_LOOP] & opt[`SACB_OPT_RECEIVER_SOURCE];
wire tx_pin = tx_line ^ inv; // [R18]
reg rx_in;
always @* begin
  if (!opt[`SACB_OPT_LOOP])
    rx_in = rx_s2; // [R6]
  else if (!opt[`SACB_OPT_RECEIVER_SOURCE])
    rx_in = tx_pin; // [R7]
  else
    rx_in = dir ? tx_pin : tl_s2; // [R7] [R20]
end
wire [3:0] rx_len = nine ? 4'd9 : 4'd8;
wire maj = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
wire noisy = ~((smp == 3'b000) | (smp == 3'b111));
wire rx_go = ctl[`SACB_CTL_RXON] & ~frozen;
wire [8:0] rx_word = nine ? rx_sh : {1'b0, rx_sh[8:1]};
wire rx_par_bad = opt[`SACB_OPT_PE] &
  (par_of(rx_word, nine, opt[`SACB_OPT_PT]) != (nine ? rx_word[8] :
  rx_word[7])); // [R12] [R13]
wire addr_mark = nine ? rx_word[8] : rx_word[7];
wire [7:0] idle_need = {`SACB_IDLE_BITS + (nine ? 4'd1 : 4'd0), 4'h0};

always @(posedge I_CLK) begin
  if (I_RESET) begin
    rx_st <= RX_IDLE;
    rx_sub <= 4'h0;
    rx_bit <= 4'h0;
    rx_sh <= 9'h000;
    smp <= 3'b111;
    rx_prev <= 1'b1;
    rx_noise <= 1'b0;
    idle_cnt <= 8'h00;
    idle_arm <= 1'b0;
  end else if (!rx_go) begin // [R14]
    rx_st <= RX_IDLE;
    idle_cnt <= 8'h00;
  end else if (tick) begin // [R21]
    rx_prev <= rx_in;
    if (!rx_in || rx_st != RX_IDLE) begin
      idle_cnt <= 8'h00;
    end else if (idle_cnt != 8'hff) begin
      idle_cnt <= idle_cnt + 8'h01; // [R11]
    end
    case (rx_st)
      RX_IDLE: begin
        if (rx_prev && !rx_in) begin // [R21]
          rx_st <= RX_START;
          rx_sub <= 4'h1;
          rx_noise <= 1'b0;
        end
      end
      RX_START: begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sub >= 4'd7 && rx_sub <= 4'd9)
          smp <= {smp[1:0], rx_in};
        if (rx_sub == 4'd15) begin
          rx_sub <= 4'h0;
          rx_bit <= 4'h0;
          if (maj) begin
            rx_st <= RX_IDLE;
          end else begin
            rx_st <= RX_DATA;
            rx_noise <= noisy;
            // [R11] ilt clear: arms idle detect here, but the count is held at zero until the stop bit ends
            idle_arm <= ~opt[`SACB_OPT_ILT];
          end
        end
      end
      RX_DATA: begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sub >= 4'd7 && rx_sub <= 4'd9)
          smp <= {smp[1:0], rx_in};
        if (rx_sub == 4'd10) begin
          rx_noise <= rx_noise | noisy; // [R19]
          if (rx_bit != rx_len)
            rx_sh <= {maj, rx_sh[8:1]}; // [R9]
        end
        if (rx_sub == 4'd15) begin
          rx_sub <= 4'h0;
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == rx_len) begin
            rx_st <= RX_IDLE;
            idle_arm <= 1'b1;
          end
        end
      end
      default: rx_st <= RX_IDLE;
    endcase
  end
end
// frame end pulse, stop bit majority ready at sub 11
wire rx_done = rx_go & tick & rx_st == RX_DATA & rx_bit == rx_len &
  rx_sub == 4'd11;
// wakeup: sleeping receiver suppresses flags until woken
wire wake_idle = ~opt[`SACB_OPT_WAKE] & idle_arm &
  (idle_cnt == idle_need); // [R10]
wire wake_addr = opt[`SACB_OPT_WAKE] & rx_done & addr_mark; // [R10]
wire idle_hit = rx_go & tick & idle_arm & (idle_cnt == idle_need);

////////////////////////////////////////////////////////////////////////////
// transmitter state machine
always @(posedge I_CLK) begin
  if (I_RESET) begin
    tx_st <= TX_IDLE;
    tx_sub <= 4'h0;
    tx_bit <= 4'h0;
    tx_sh <= 10'h3ff;
    tx_line <= 1'b1;
    tx_busy <= 1'b0;
  end else if (frozen) begin // [R14]
    tx_st <= tx_st;
  end else begin
    case (tx_st)
      TX_IDLE: begin
        tx_line <= 1'b1;
        tx_busy <= 1'b0;
        if (tx_take && ctl[`SACB_CTL_BRK]) begin
          tx_st <= TX_BRK;
          tx_sub <= 4'h0;
          tx_bit <= 4'h0;
          tx_line <= 1'b0;
          tx_busy <= 1'b1;
        end else if (tx_take && !tx_empty) begin
          tx_st <= TX_DATA;
          tx_sub <= 4'h0;
          tx_bit <= 4'h0;
          tx_sh <= nine ? {tx_fr, 1'b0} : {1'b1, tx_fr[7:0], 1'b0};
          tx_line <= 1'b0;
          tx_busy <= 1'b1;
        end
      end
      TX_DATA: begin
        if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == 4'd15) begin
            tx_bit <= tx_bit + 4'h1;
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_line <= tx_sh[1]; // [R9]
            if (tx_bit == 4'd9 && !nine)
              tx_line <= 1'b1;
            if (tx_bit == tx_len - 4'd1) begin
              tx_st <= TX_IDLE;
              tx_line <= 1'b1;
            end
          end
        end
      end
      TX_BRK: begin
        if (tick) begin
          tx_sub <= tx_sub + 4'h1;
          if (tx_sub == 4'd15) begin
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == brk_len - 4'd1) begin // [R15]
              tx_st <= TX_IDLE;
              tx_line <= 1'b1;
            end
          end
        end
      end
      default: tx_st <= TX_IDLE;
    endcase
  end
end
wire tx_load = !frozen && tx_take && !ctl[`SACB_CTL_BRK] && !tx_empty;
wire tx_fin = !frozen && tick && tx_st != TX_IDLE && tx_sub == 4'd15 &&
  tx_bit == ((tx_st == TX_BRK) ? brk_len : tx_len) - 4'd1;

////////////////////////////////////////////////////////////////////////////
// register file
wire clr = wr && I_PADDR == `SACB_OFF_STAT;
wire rd_data = acc && !I_PWRITE && I_PADDR == `SACB_OFF_DATA;
always @(posedge I_CLK) begin
  if (I_RESET) begin
    bdh_buf <= 5'h00;
    div_hi <= 5'h00;
    div_lo <= `SACB_BDL_RST; // [R4]
    opt <= 8'h00;
    ctl <= 4'h0;
    t9 <= 1'b0;
    dir <= 1'b0;
    inv <= 1'b0;
    brk13 <= 1'b0;
    gen_on <= 1'b0;
    tx_buf <= 8'h00;
    tx_buf9 <= 1'b0;
    tx_empty <= 1'b1;
    rx_buf <= 8'h00;
    rx_buf9 <= 1'b0;
    rx_full <= 1'b0;
    {f_or, f_pf, f_fe, f_nf, f_idle, f_tc} <= 6'h00;
  end else begin
    if (wr && I_PADDR == `SACB_OFF_BDH)
      bdh_buf <= I_PWDATA[4:0]; // [R3] [R5]
    if (wr && I_PADDR == `SACB_OFF_BDL) begin
      div_hi <= bdh_buf; // [R3]
      div_lo <= I_PWDATA[7:0];
    end
    if (wr && I_PADDR == `SACB_OFF_OPT)
      opt <= I_PWDATA[7:0];
    if (wr && I_PADDR == `SACB_OFF_CTL) begin
      ctl <= I_PWDATA[3:0];
      if (I_PWDATA[`SACB_CTL_TXON] | I_PWDATA[`SACB_CTL_RXON])
        gen_on <= 1'b1; // [R4]
    end
    if (wr && I_PADDR == `SACB_OFF_EXT) begin
      t9 <= I_PWDATA[`SACB_EXT_T9];
      dir <= I_PWDATA[`SACB_EXT_DIR];
      inv <= I_PWDATA[`SACB_EXT_INV];
      brk13 <= I_PWDATA[`SACB_EXT_BRK13];
    end
    // host is expected to write only while empty; later writes overwrite
    if (wr && I_PADDR == `SACB_OFF_DATA) begin // [R16]
      tx_buf <= I_PWDATA[7:0];
      tx_buf9 <= t9; // [R17]
      tx_empty <= 1'b0;
    end else if (tx_load) begin
      tx_empty <= 1'b1;
    end
    if (rd_data)
      rx_full <= 1'b0; // [R16]
    if (ctl[`SACB_CTL_SLEEP] && (wake_idle || wake_addr))
      ctl[`SACB_CTL_SLEEP] <= 1'b0; // [R10]
    // clears first so that a same-cycle hardware set wins
    if (clr) begin
      f_or <= f_or & ~I_PWDATA[3];
      f_nf <= f_nf & ~I_PWDATA[2];
      f_fe <= f_fe & ~I_PWDATA[1];
      f_pf <= f_pf & ~I_PWDATA[0];
      f_idle <= f_idle & ~I_PWDATA[4];
      f_tc <= f_tc & ~I_PWDATA[6];
    end
    if (tx_fin)
      f_tc <= 1'b1;
    if (idle_hit && !ctl[`SACB_CTL_SLEEP])
      f_idle <= 1'b1;
    if (rx_done && (!ctl[`SACB_CTL_SLEEP] || wake_addr)) begin
      if (rx_full && !rd_data) begin
        f_or <= 1'b1; // [R19]
      end else begin
        rx_buf <= rx_word[7:0];
        rx_buf9 <= nine & rx_word[8]; // [R17]
        rx_full <= 1'b1;
        if (!maj) f_fe <= 1'b1; // [R19]
        if (rx_par_bad) f_pf <= 1'b1; // [R19]
        if (rx_noise || noisy) f_nf <= 1'b1; // [R19]
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// apb answer and pins
always @(posedge I_CLK) begin
  if (I_RESET) begin
    O_PRDATA <= 32'h00000000;
    O_PREADY <= 1'b0;
    O_PSLVERR <= 1'b0;
    O_TXD <= 1'b1;
    O_TXD_OE <= 1'b0;
  end else begin
    O_PREADY <= acc;
    O_PSLVERR <= acc & ~known;
    O_PRDATA <= 32'h00000000;
    if (acc && !I_PWRITE) begin
      case (I_PADDR)
        `SACB_OFF_BDH: O_PRDATA <= {27'h0, div_hi};
        `SACB_OFF_BDL: O_PRDATA <= {24'h0, div_lo};
        `SACB_OFF_OPT: O_PRDATA <= {24'h0, opt};
        `SACB_OFF_CTL: O_PRDATA <= {28'h0, ctl};
        `SACB_OFF_STAT: O_PRDATA <= {24'h0, tx_empty, f_tc, rx_full,
          f_idle, f_or, f_nf, f_fe, f_pf};
        `SACB_OFF_DATA: O_PRDATA <= {24'h0, rx_buf};
        `SACB_OFF_EXT: O_PRDATA <= {24'h0, rx_buf9, t9, dir, inv, brk13,
          3'h0};
        default: O_PRDATA <= 32'h00000000;
      endcase
    end
    O_TXD <= tx_pin; // [R18]
    O_TXD_OE <= (ctl[`SACB_CTL_TXON] | tx_busy) & ~I_STOP &
      (~single | dir); // [R20]
  end
end

endmodule

// ===== tb/sacb_props.sv
// Purpose: apb answer and stop-mode checks on the uart core ports
// Assumes: one clock, synchronous active high reset
// Notes: bound to sacb_core at the foot of this file
`timescale 1ns/1ps
module sacb_props (
  input wire I_CLK, // clock
  input wire I_RESET, // reset
  input wire I_PSEL, // apb select
  input wire I_PENABLE, // apb enable
  input wire I_PWRITE, // apb direction
  input wire [11:0] I_PADDR, // apb address
  input wire I_STOP, // stop mode
  input wire [31:0] O_PRDATA, // read data
  input wire O_PREADY, // ready
  input wire O_PSLVERR, // error
  input wire O_TXD_OE // pin enable
);
  wire acc = I_PSEL && I_PENABLE && !O_PREADY;
  wire bad = I_PADDR > 12'h018 || I_PADDR[1:0] != 2'b00;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  ////////////////////////////////////////////////////////////////////////
  property p_wait; acc |=> O_PREADY; endproperty
  a_wait: assert property (p_wait)
    else $error("access not answered next cycle");
  property p_idle; !(I_PSEL && I_PENABLE) |=> !O_PREADY; endproperty
  a_idle: assert property (p_idle)
    else $error("ready without access");
  property p_pulse; O_PREADY |=> !O_PREADY; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_err; O_PSLVERR |-> O_PREADY; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_bad; acc && bad |=> O_PSLVERR; endproperty
  a_bad: assert property (p_bad)
    else $error("unmapped access not refused");
  property p_good; acc && !bad |=> !O_PSLVERR; endproperty
  a_good: assert property (p_good)
    else $error("mapped access refused");
  property p_rdz; acc && bad && !I_PWRITE |=> O_PRDATA == 32'h0;
  endproperty
  a_rdz: assert property (p_rdz)
    else $error("unmapped read not zero");
  property p_stop; I_STOP ##1 I_STOP |-> !O_TXD_OE; endproperty
  a_stop: assert property (p_stop)
    else $error("pin driven in stop mode");
endmodule
bind sacb_core sacb_props u_props (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR), .I_STOP(I_STOP), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TXD_OE(O_TXD_OE));

// ===== tb/sacb_peer.sv
// Purpose: remote serial transmitter feeding the core receive pin
// Assumes: bit length given in clocks, divisor 1 means 16
// Notes: line rests at mark level between frames
`timescale 1ns/1ps
module sacb_peer #(parameter BIT_CLKS = 16) (
  input wire i_clk, // bench clock
  output reg o_rxd // line into the core
);
  integer k;
  initial o_rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task send(input [7:0] d);
    reg [9:0] f;
    begin
      f = {1'b1, d, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        @(posedge i_clk);
        o_rxd <= f[k];
        repeat (BIT_CLKS - 1) @(posedge i_clk);
      end
      @(posedge i_clk);
    end
  endtask
endmodule

// ===== tb/sacb_core_tb_top.sv
// Purpose: self-checking bench for the uart core
// Assumes: divisor 1 gives sixteen clocks per bit
// Notes: register rows first, then frames, loop_select and odd cases
`timescale 1ns/1ps
module sacb_core_tb_top;
  reg I_CLK = 0;
  reg I_RESET = 1;
  reg psel = 0, pen = 0, pwr = 0, wt = 0, stp = 0;
  reg [11:0] pa = 0;
  reg [31:0] pwd = 0;
  wire rxd, txd, oe, rdy, err;
  wire [31:0] prd;
  wire txd_in = oe ? txd : 1'b1; // pull-up when nobody drives
  integer fails = 0, check_count = 0, i, j;
  reg [31:0] r;
  reg e;
  reg [8:0] b;
  // w, err, addr, wdata, expected read
  // high half reads back its working value, so 1f only after the low write
  reg [31:0] rows [0:12] = '{32'h0000_0000, 32'h0004_0004, 32'h8008_a500,
    32'h0008_00a5, 32'h8008_0000, 32'h8000_ff00, 32'h0000_0000,
    32'h8004_0400, 32'h0000_001f, 32'h8000_0000, 32'h401c_0000,
    32'hc020_5500, 32'h4002_0000};
  reg [7:0] opts [0:4] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h13};
  sacb_core u_dut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
    .I_WAIT(wt), .I_STOP(stp), .I_RXD(rxd), .I_TXD_IN(txd_in),
    .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .O_TXD(txd),
    .O_TXD_OE(oe));
  sacb_peer u_peer (.i_clk(I_CLK), .o_rxd(rxd));
  initial forever #10 I_CLK = ~I_CLK;
  ////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      check_count = check_count + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge I_CLK);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge I_CLK);
      pen <= 1;
      n = 0;
      do begin
        @(posedge I_CLK);
        n = n + 1;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1)
        chk(rdy, 1);
      r = prd;
      e = err;
      psel <= 0;
      pen <= 0;
    end
  endtask
  // sends one character and samples the pin at bit centres
  task sendc(input [7:0] opt, input [8:0] d);
    integer k, n;
    begin
      n = opt[4] ? 9 : 8;
      b = d & (opt[4] ? 9'h1ff : 9'h0ff);
      if (opt[1])
        b[n-1] = ^(b & ~(9'h1 << (n - 1))) ^ opt[0];
      apb(1, 12'h008, opt);
      apb(1, 12'h018, {d[8], 6'h20});
      fork
        apb(1, 12'h014, {24'h0, d[7:0]});
        begin
          k = 0;
          while (txd !== 1'b0 && k < 400) begin
            @(posedge I_CLK);
            k = k + 1;
          end
          repeat (8) @(posedge I_CLK);
          chk(txd, 0);
          for (k = 0; k <= n; k = k + 1) begin
            repeat (16) @(posedge I_CLK);
            chk(txd, k < n ? b[k] : 1'b1);
          end
        end
      join
      repeat (16) @(posedge I_CLK);
    end
  endtask
  task rxchk(input [7:0] x);
    integer k;
    begin
      k = 0;
      r = 0;
      while (r[5] !== 1'b1 && k < 100) begin
        apb(0, 12'h010, 0);
        k = k + 1;
      end
      apb(0, 12'h014, 0);
      chk(r, {24'h0, x});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge I_CLK);
    fails = fails + 1;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge I_CLK);
    I_RESET <= 0;
    @(posedge I_CLK);
    chk(txd, 1);
    chk(oe, 0);
    for (i = 0; i < 13; i = i + 1) begin
      apb(rows[i][31], rows[i][27:16], rows[i][15:8]);
      chk(e, rows[i][30]);
      if (!rows[i][31])
        chk(r, rows[i][7:0]);
    end
    apb(1, 12'h004, 1);
    apb(1, 12'h00c, 8'h0c);
    for (i = 0; i < 5; i = i + 1)
      sendc(opts[i], 9'h1a5);
    for (i = 0; i < 2; i = i + 1) begin
      sendc(i ? 8'ha0 : 8'h80, 9'h05a);
      rxchk(8'h5a);
    end
    apb(1, 12'h008, 0);
    u_peer.send(8'h3c);
    rxchk(8'h3c);
    // stop-in-wait: a queued character must not start while waiting
    apb(1, 12'h008, 8'h40);
    wt <= 1;
    apb(1, 12'h014, 8'h99);
    j = 0;
    repeat (40) begin
      @(posedge I_CLK);
      if (txd !== 1'b1)
        j = 1;
    end
    chk(j, 0);
    wt <= 0;
    repeat (8) @(posedge I_CLK);
    chk(txd, 0);
    repeat (200) @(posedge I_CLK);
    // long break: low run measured in clocks, divisor 1
    apb(1, 12'h018, 8'h28);
    apb(1, 12'h00c, 8'h0d);
    j = 0;
    while (txd !== 1'b0 && j < 400) begin
      @(posedge I_CLK);
      j = j + 1;
    end
    j = 0;
    fork
      apb(1, 12'h00c, 8'h0c);
      while (txd === 1'b0 && j < 400) begin
        @(posedge I_CLK);
        j = j + 1;
      end
    join
    chk(j, 13 * 16);
    repeat (20) @(posedge I_CLK);
    // high half alone must not move the rate
    apb(1, 12'h000, 1);
    sendc(8'h00, 9'h0c3);
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 0);
    apb(1, 12'h014, 8'hff);
    j = 0;
    repeat (300) begin
      @(posedge I_CLK);
      if (txd !== 1'b1)
        j = 1;
    end
    chk(j, 0);
    apb(1, 12'h018, 8'h30);
    repeat (4) @(posedge I_CLK);
    chk(txd, 0);
    stp <= 1;
    repeat (3) @(posedge I_CLK);
    chk(oe, 0);
    stp <= 0;
    I_RESET <= 1;
    repeat (2) @(posedge I_CLK);
    I_RESET <= 0;
    apb(0, 12'h004, 0);
    chk(r, 8'h04);
    apb(0, 12'h018, 0);
    chk(r, 0);
    tally_and_finish;
  end
endmodule
